// ---- core/llp_consts.svh ----
// named offsets, field positions, reset values and counts of the loop controller
`ifndef LLP_CONSTS_SVH
`define LLP_CONSTS_SVH
`define LLP_DW 16
`define LLP_STAGES 7
`define LLP_ST_D 0
`define LLP_ST_AD 1
`define LLP_ST_AC1 2
`define LLP_ST_AC2 3
`define LLP_ST_R 4
`define LLP_ST_X 5
`define LLP_ST_W 6
`define LLP_INTERLOCK_CYC 4
`define LLP_RST_VAL 16'h0000
`define LLP_ONE 16'h0001
`define LLP_OFF_CTRL 8'h00
`define LLP_OFF_STATUS 8'h04
`define LLP_OFF_RPT 8'h08
`define LLP_OFF_BRC 8'h0C
`define LLP_OFF_BRS 8'h10
`define LLP_OFF_LOOP0 8'h14
`define LLP_OFF_LOOP1 8'h18
`define LLP_CTRL_FREEZE 0
`define LLP_STAT_ACT0 0
`define LLP_STAT_ACT1 1
`define LLP_STAT_ARMED 2
`define LLP_STAT_STALL_D 3
`define LLP_STAT_STALL_AD 4
`define LLP_LO 15:0
`define LLP_HI 31:16
`endif

// ---- core/llp_pkg.sv ----
// types shared by the loop controller modules
`include "llp_consts.svh"
package llp_pkg;
  typedef enum logic [1:0] {llp_k_normal, llp_k_single, llp_k_block, llp_k_imm} llp_kind_t;
  typedef enum logic [3:0] {
    llp_r_none, llp_r_repeat_counter, llp_r_csr, llp_r_block_iteration_counter_0, llp_r_block_iteration_counter_1, llp_r_block_count_save_1,
    llp_r_loop_start_address_0, llp_r_loop_start_address_1, llp_r_loop_end_address_0, llp_r_loop_end_address_1, llp_r_cdp, llp_r_ar1
  } llp_reg_t;
  typedef struct packed {
    logic valid;
    llp_kind_t kind;
    llp_reg_t rd_reg;
    llp_reg_t ad_rd_reg;
    llp_reg_t wr_reg;
    logic level;
    logic use_const;
    logic loop_back;
    logic [`LLP_DW-1:0] imm;
    logic [`LLP_DW-1:0] pc;
  } llp_instr_t;
  typedef struct packed {
    logic [`LLP_DW-1:0] repeat_counter;
    logic [`LLP_DW-1:0] csr;
    logic [`LLP_DW-1:0] block_iteration_counter_0;
    logic [`LLP_DW-1:0] block_iteration_counter_1;
    logic [`LLP_DW-1:0] block_count_save_1;
    logic [`LLP_DW-1:0] loop_start_address_0;
    logic [`LLP_DW-1:0] loop_start_address_1;
    logic [`LLP_DW-1:0] loop_end_address_0;
    logic [`LLP_DW-1:0] loop_end_address_1;
    logic [1:0] act;
    logic armed;
    logic stall_d;
    logic stall_ad;
  } llp_view_t;
endpackage

// ---- core/llp_hazard.sv ----
// interlock detection for the loop-control registers
`timescale 1ns/1ps
`include "llp_consts.svh"
module llp_hazard
  import llp_pkg::*;
(
  input llp_instr_t i_st [`LLP_STAGES],
  input wire logic i_last_d,
  input llp_reg_t i_brc_reg,
  output logic o_stall_ad,
  output logic o_stall_d_brc
);
  // imm loads finish in AD, so they never count as execute-stage writers
  // a counter one write also lands in its save register, so it guards that too
  function automatic logic x_writes(input llp_instr_t s, input llp_reg_t r);
    x_writes = s.valid && (s.kind != llp_k_imm) && (r != llp_r_none) &&
               ((s.wr_reg == r) || (r == llp_r_block_count_save_1 && s.wr_reg == llp_r_block_iteration_counter_1));
  endfunction

  llp_reg_t src_rpt;
  always_comb begin
    src_rpt = llp_r_none;
    if (i_st[`LLP_ST_AD].kind == llp_k_single && !i_st[`LLP_ST_AD].use_const) begin
      src_rpt = llp_r_csr;
    end else if (i_st[`LLP_ST_AD].kind == llp_k_block && i_st[`LLP_ST_AD].level) begin
      src_rpt = llp_r_block_count_save_1;
    end
  end

  always_comb begin
    o_stall_ad = 1'b0;
    o_stall_d_brc = 1'b0;
    for (int k = `LLP_ST_AC1; k <= `LLP_ST_X; k++) begin
      // per-register match: a write to one pointer never holds a read of another
      if (i_st[`LLP_ST_AD].valid && (x_writes(i_st[k], src_rpt) ||
          x_writes(i_st[k], i_st[`LLP_ST_AD].ad_rd_reg))) begin
        o_stall_ad = 1'b1;
      end
    end
    for (int k = `LLP_ST_AD; k <= `LLP_ST_R; k++) begin
      if (i_last_d && i_st[k].valid && i_st[k].rd_reg == i_brc_reg) begin
        o_stall_d_brc = 1'b1;
      end
    end
  end
endmodule

// ---- core/llp_apb.sv ----
// apb slave: control word and read-only view of the loop registers
`timescale 1ns/1ps
`include "llp_consts.svh"
module llp_apb
  import llp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input llp_view_t i_view,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_freeze
);
  logic [31:0] rd;
  logic hit;
  always_comb begin
    rd = 32'h00000000;
    hit = 1'b1;
    unique case (i_paddr)
      `LLP_OFF_CTRL: rd[`LLP_CTRL_FREEZE] = o_freeze;
      `LLP_OFF_STATUS: begin
        rd[`LLP_STAT_ACT0] = i_view.act[0];
        rd[`LLP_STAT_ACT1] = i_view.act[1];
        rd[`LLP_STAT_ARMED] = i_view.armed;
        rd[`LLP_STAT_STALL_D] = i_view.stall_d;
        rd[`LLP_STAT_STALL_AD] = i_view.stall_ad;
      end
      `LLP_OFF_RPT: rd = {i_view.csr, i_view.repeat_counter};
      `LLP_OFF_BRC: rd = {i_view.block_iteration_counter_1, i_view.block_iteration_counter_0};
      `LLP_OFF_BRS: rd[`LLP_LO] = i_view.block_count_save_1;
      `LLP_OFF_LOOP0: rd = {i_view.loop_end_address_0, i_view.loop_start_address_0};
      `LLP_OFF_LOOP1: rd = {i_view.loop_end_address_1, i_view.loop_start_address_1};
      default: hit = 1'b0;
    endcase
  end

  // zero wait states; a frozen clock enable also holds the bus off
  assign o_pready = i_ce;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata <= i_pwrite ? 32'h00000000 : rd;
      o_pslverr <= !hit;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_freeze <= 1'b0;
    end else if (i_ce && i_psel && i_penable && i_pwrite && i_paddr == `LLP_OFF_CTRL) begin
      o_freeze <= i_pwdata[`LLP_CTRL_FREEZE];
    end
  end
endmodule

// ---- core/llp_core.sv ----
// seven-stage pipeline model with hardware loop registers and their interlocks
// Overview of operation
// - separate registers never interlock each other
// - plain accesses read in R, write in X
// - single repeat loads counter in its AD
// - repeated instruction tests, decrements counter in AD
// - level-one block repeat copies save into counter one
// - block repeat loads start/end in AD
// - counter decremented in D of last instruction
// - end address compared in D each instruction, start address read in AD
// - counter read near loop end stalls D four
// - last instruction reading counter sees decremented value
// - counter one loads also load its save
// - repeat source written in X stalls AD four
// - immediate loads of counter/source happen in AD
`timescale 1ns/1ps
`include "llp_consts.svh"
module llp_core
  import llp_pkg::*;
#(
  parameter int STAGES = `LLP_STAGES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input llp_instr_t i_instr,
  input wire logic [`LLP_DW-1:0] i_x_wdata,
  output logic o_ready,
  output logic o_stall,
  output logic o_r_valid,
  output logic [`LLP_DW-1:0] o_r_rdata,
  output logic o_redirect,
  output logic [`LLP_DW-1:0] o_redirect_pc,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  if (STAGES != `LLP_STAGES) begin : g_bad_stages
    $error("llp_core supports exactly seven stages");
  end

  llp_instr_t st [`LLP_STAGES];
  logic [`LLP_DW-1:0] repeat_counter, csr, block_count_save_1;
  logic [`LLP_DW-1:0] brc [2];
  logic [`LLP_DW-1:0] rsa [2];
  logic [`LLP_DW-1:0] rea [2];
  logic [1:0] act;
  logic armed;
  logic freeze, run, lvl, last_d, dec, ad_go, replay, stall_ad, stall_d_brc;
  logic [1:0] held;
  llp_reg_t brc_reg;
  llp_instr_t d_out, next_d;
  llp_view_t view;
  llp_reg_t wp_id [2];
  logic [`LLP_DW-1:0] wp_val [2];

  function automatic logic [`LLP_DW-1:0] read_reg(input llp_reg_t r);
    unique case (r)
      llp_r_repeat_counter: read_reg = repeat_counter;
      llp_r_csr: read_reg = csr;
      llp_r_block_iteration_counter_0: read_reg = brc[0];
      llp_r_block_iteration_counter_1: read_reg = brc[1];
      llp_r_block_count_save_1: read_reg = block_count_save_1;
      llp_r_loop_start_address_0: read_reg = rsa[0];
      llp_r_loop_start_address_1: read_reg = rsa[1];
      llp_r_loop_end_address_0: read_reg = rea[0];
      llp_r_loop_end_address_1: read_reg = rea[1];
      default: read_reg = `LLP_RST_VAL;
    endcase
  endfunction

  // innermost active loop: level one nests inside level zero
  assign lvl = act[1];
  assign brc_reg = lvl ? llp_r_block_iteration_counter_1 : llp_r_block_iteration_counter_0;
  assign run = i_ce && !freeze;
  assign last_d = st[`LLP_ST_D].valid && act[lvl] && (st[`LLP_ST_D].pc == rea[lvl]);

  llp_hazard u_hazard (
    .i_st(st),
    .i_last_d(last_d),
    .i_brc_reg(brc_reg),
    .o_stall_ad(stall_ad),
    .o_stall_d_brc(stall_d_brc)
  );

  // repeated instruction is re-issued from AD until the counter runs out
  assign ad_go = run && st[`LLP_ST_AD].valid && !stall_ad;
  assign replay = armed && st[`LLP_ST_AD].valid && !stall_ad &&
                  (st[`LLP_ST_AD].kind == llp_k_normal) && (repeat_counter != `LLP_RST_VAL);
  always_comb begin
    if (stall_ad || replay) begin
      held = 2'd2;
    end else if (stall_d_brc) begin
      held = 2'd1;
    end else begin
      held = 2'd0;
    end
  end
  assign dec = run && (held == 2'd0) && last_d;
  assign o_ready = run && (held == 2'd0);
  assign o_stall = held != 2'd0;

  always_comb begin
    next_d = i_instr;
    next_d.loop_back = 1'b0;
    d_out = st[`LLP_ST_D];
    d_out.loop_back = dec && (brc[lvl] != `LLP_RST_VAL);
  end

  // held stages keep their slot; the first moving stage takes a bubble, or a copy of AD on a replay
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < `LLP_STAGES; i++) begin
        st[i] <= '0;
      end
    end else if (run) begin
      for (int i = 0; i < `LLP_STAGES; i++) begin
        if (i >= int'(held)) begin
          if (i == `LLP_ST_D) begin
            st[i] <= next_d;
          end else if (i == int'(held) && !replay && held != 2'd0) begin
            st[i] <= '0;
          end else if (i == `LLP_ST_AD) begin
            st[i] <= d_out;
          end else begin
            st[i] <= st[i-1];
          end
        end
      end
    end
  end

  // port 0 is the execute-stage write, port 1 an immediate load in AD
  always_comb begin
    wp_id[0] = llp_r_none;
    wp_val[0] = i_x_wdata;
    wp_id[1] = llp_r_none;
    wp_val[1] = st[`LLP_ST_AD].imm;
    if (st[`LLP_ST_X].valid && st[`LLP_ST_X].kind != llp_k_imm) begin
      wp_id[0] = st[`LLP_ST_X].wr_reg;
    end
    if (ad_go && st[`LLP_ST_AD].kind == llp_k_imm) begin
      wp_id[1] = st[`LLP_ST_AD].wr_reg;
    end
  end

  // later sources in program order are assigned last so they win
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      repeat_counter <= `LLP_RST_VAL;
      csr <= `LLP_RST_VAL;
      block_count_save_1 <= `LLP_RST_VAL;
      brc <= '{`LLP_RST_VAL, `LLP_RST_VAL};
      rsa <= '{`LLP_RST_VAL, `LLP_RST_VAL};
      rea <= '{`LLP_RST_VAL, `LLP_RST_VAL};
      act <= 2'b00;
      armed <= 1'b0;
    end else if (run) begin
      for (int p = 0; p < 2; p++) begin
        unique case (wp_id[p])
          llp_r_repeat_counter: repeat_counter <= wp_val[p];
          llp_r_csr: csr <= wp_val[p];
          llp_r_block_iteration_counter_0: brc[0] <= wp_val[p];
          llp_r_block_iteration_counter_1: begin
            brc[1] <= wp_val[p];
            block_count_save_1 <= wp_val[p];
          end
          llp_r_block_count_save_1: block_count_save_1 <= wp_val[p];
          llp_r_loop_start_address_0: rsa[0] <= wp_val[p];
          llp_r_loop_start_address_1: rsa[1] <= wp_val[p];
          llp_r_loop_end_address_0: rea[0] <= wp_val[p];
          llp_r_loop_end_address_1: rea[1] <= wp_val[p];
          default: ;
        endcase
      end
      if (ad_go && st[`LLP_ST_AD].kind == llp_k_single) begin
        repeat_counter <= st[`LLP_ST_AD].use_const ? st[`LLP_ST_AD].imm : csr;
        armed <= 1'b1;
      end else if (ad_go && armed && st[`LLP_ST_AD].kind == llp_k_normal) begin
        if (replay) begin
          repeat_counter <= repeat_counter - `LLP_ONE;
        end else begin
          armed <= 1'b0;
        end
      end
      if (ad_go && st[`LLP_ST_AD].kind == llp_k_block) begin
        rsa[st[`LLP_ST_AD].level] <= st[`LLP_ST_AD].pc + `LLP_ONE;
        rea[st[`LLP_ST_AD].level] <= st[`LLP_ST_AD].imm;
        act[st[`LLP_ST_AD].level] <= 1'b1;
        if (st[`LLP_ST_AD].level) begin
          brc[1] <= block_count_save_1;
        end
      end
      // the decrement belongs to the youngest instruction, so it comes last
      if (dec) begin
        if (brc[lvl] != `LLP_RST_VAL) begin
          brc[lvl] <= brc[lvl] - `LLP_ONE;
        end else begin
          act[lvl] <= 1'b0;
        end
      end
    end
  end

  // loop-back target comes from the start address read in AD
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_redirect <= 1'b0;
      o_redirect_pc <= `LLP_RST_VAL;
    end else if (i_ce) begin
      o_redirect <= ad_go && st[`LLP_ST_AD].loop_back;
      if (ad_go && st[`LLP_ST_AD].loop_back) begin
        o_redirect_pc <= rsa[lvl];
      end
    end
  end

  // read stage access; a last instruction sees its own decrement here
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_r_valid <= 1'b0;
      o_r_rdata <= `LLP_RST_VAL;
    end else if (run) begin
      o_r_valid <= st[`LLP_ST_R].valid && st[`LLP_ST_R].rd_reg != llp_r_none;
      o_r_rdata <= read_reg(st[`LLP_ST_R].rd_reg);
    end
  end

  always_comb begin
    view.repeat_counter = repeat_counter;
    view.csr = csr;
    view.block_iteration_counter_0 = brc[0];
    view.block_iteration_counter_1 = brc[1];
    view.block_count_save_1 = block_count_save_1;
    view.loop_start_address_0 = rsa[0];
    view.loop_start_address_1 = rsa[1];
    view.loop_end_address_0 = rea[0];
    view.loop_end_address_1 = rea[1];
    view.act = act;
    view.armed = armed;
    view.stall_d = stall_d_brc;
    view.stall_ad = stall_ad;
  end

  llp_apb u_apb (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_view(view),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_freeze(freeze)
  );

  chk_brc_interlock: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (last_d && st[`LLP_ST_AD].valid && st[`LLP_ST_AD].rd_reg == brc_reg)
    |-> stall_d_brc [*4]) else $error("counter read did not hold D four cycles");
  chk_src_interlock: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st[`LLP_ST_AD].valid && st[`LLP_ST_AD].kind == llp_k_single &&
     !st[`LLP_ST_AD].use_const && st[`LLP_ST_AC1].valid &&
     st[`LLP_ST_AC1].kind != llp_k_imm && st[`LLP_ST_AC1].wr_reg == llp_r_csr)
    |-> stall_ad [*4]) else $error("repeat source write did not hold AD four cycles");
  chk_save_interlock: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st[`LLP_ST_AD].valid && st[`LLP_ST_AD].kind == llp_k_block && st[`LLP_ST_AD].level &&
     st[`LLP_ST_AC1].valid && st[`LLP_ST_AC1].kind != llp_k_imm &&
     st[`LLP_ST_AC1].wr_reg == llp_r_block_iteration_counter_1)
    |-> stall_ad [*4]) else $error("save register write did not hold AD four cycles");
  chk_fine_grain: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st[`LLP_ST_AD].valid && st[`LLP_ST_AD].kind == llp_k_normal &&
     st[`LLP_ST_AD].ad_rd_reg == llp_r_ar1 && st[`LLP_ST_AC1].wr_reg == llp_r_cdp &&
     st[`LLP_ST_AC2].wr_reg != llp_r_ar1 && st[`LLP_ST_R].wr_reg != llp_r_ar1 &&
     st[`LLP_ST_X].wr_reg != llp_r_ar1 && st[`LLP_ST_AC1].wr_reg != llp_r_ar1)
    |-> !stall_ad) else $error("pointer read held by another pointer write");
  chk_rpt_load: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ad_go && st[`LLP_ST_AD].kind == llp_k_single)
    |=> repeat_counter == ($past(st[`LLP_ST_AD].use_const) ? $past(st[`LLP_ST_AD].imm) : $past(csr))
    && armed) else $error("repeat counter not loaded in AD");
  chk_rpt_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (run && replay) |=> (repeat_counter == $past(repeat_counter) - `LLP_ONE) && st[`LLP_ST_AC1] == $past(st[`LLP_ST_AD]))
    else $error("repeated instruction not re-issued with decrement");
  chk_save_copy: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ad_go && st[`LLP_ST_AD].kind == llp_k_block && st[`LLP_ST_AD].level && !dec)
    |=> brc[1] == $past(block_count_save_1) && rea[1] == $past(st[`LLP_ST_AD].imm))
    else $error("block repeat did not load counter one and end");
  chk_save_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (run && (wp_id[0] == llp_r_block_iteration_counter_1 || wp_id[1] == llp_r_block_iteration_counter_1) && !dec &&
     !(ad_go && st[`LLP_ST_AD].kind == llp_k_block))
    |=> block_count_save_1 == brc[1]) else $error("save register not mirrored");
  chk_last_dec: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (dec && brc[lvl] != `LLP_RST_VAL && !(ad_go && st[`LLP_ST_AD].kind == llp_k_block))
    |=> brc[$past(lvl)] == $past(brc[lvl]) - `LLP_ONE && st[`LLP_ST_AD].loop_back)
    else $error("loop counter not decremented at D exit");
  chk_pipe_order: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (run && held == 2'd0) |=> st[`LLP_ST_W] == $past(st[`LLP_ST_X]) &&
    st[`LLP_ST_R] == $past(st[`LLP_ST_AC2])) else $error("pipeline did not advance");
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the loop controller pipeline and its apb view
`timescale 1ns/1ps
`include "llp_consts.svh"
module tb_top;
  import llp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  llp_instr_t i_instr = '0;
  logic [15:0] i_x_wdata = 16'h0000;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic o_ready;
  logic o_stall;
  logic o_r_valid;
  logic [15:0] o_r_rdata;
  logic o_redirect;
  logic [15:0] o_redirect_pc;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int waits = 0;
  logic saw_redir = 1'b0;
  logic [15:0] exp_q [$];
  logic [31:0] lfsr = 32'h0001043C;

  llp_core #(.STAGES(`LLP_STAGES)) u_dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_instr(i_instr),
    .i_x_wdata(i_x_wdata), .o_ready(o_ready), .o_stall(o_stall), .o_r_valid(o_r_valid),
    .o_r_rdata(o_r_rdata), .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr)
  );

  initial begin
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic llp_instr_t mk(llp_kind_t k, llp_reg_t rd, llp_reg_t ad, llp_reg_t wr,
      logic uc, logic [15:0] imm, logic [15:0] pc);
    llp_instr_t t;
    t = '0;
    t.valid = 1'b1;
    t.kind = k;
    t.rd_reg = rd;
    t.ad_rd_reg = ad;
    t.wr_reg = wr;
    t.use_const = uc;
    t.imm = imm;
    t.pc = pc;
    return t;
  endfunction

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmpn(int e, int g);
    n_compared++;
    if (e != g) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // o_ready comes from registered state and i_ce only, so it is judged at the taking edge itself
  task automatic issue(llp_instr_t ins);
    i_instr <= ins;
    do begin
      @(posedge i_ref_clk);
      if (o_redirect === 1'b1) saw_redir = 1'b1;
      if (o_ready !== 1'b1) begin
        waits++;
        cmp(32'h00000001, {31'h0, o_stall});
      end
    end while (o_ready !== 1'b1);
  endtask

  task automatic drain(int n);
    repeat (n) issue('0);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
      output logic e);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    // an idle edge keeps the next setup from reassigning the strobes in this step
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, logic expe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    cmp(exp, q);
    cmp({31'h0, expe}, {31'h0, e});
  endtask

  // read results stand one run cycle, so they are taken mid-cycle
  always @(negedge i_ref_clk) begin
    if (i_resetn === 1'b1 && o_r_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("[ERR] t=%0t exp=none got=%h", $time, o_r_rdata);
      end else begin
        cmp({16'h0, exp_q.pop_front()}, {16'h0, o_r_rdata});
      end
    end
  end

  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] w;
    logic [15:0] n;
    llp_instr_t b;
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    for (int a = 4; a <= 24; a += 4) rd(8'(a), 32'h00000000, 1'b0);
    rd(8'h1C, 32'h00000000, 1'b1);
    apb(1'b1, `LLP_OFF_CTRL, 32'h00000001, q, e);
    @(negedge i_ref_clk);
    cmp(32'h00000000, {31'h0, o_ready});
    cmp(32'h00000000, {31'h0, o_stall});
    @(posedge i_ref_clk);
    rd(`LLP_OFF_CTRL, 32'h00000001, 1'b0);
    apb(1'b1, `LLP_OFF_CTRL, 32'h00000000, q, e);
    $display("test register view done");
    for (int k = 0; k < 2; k++) begin
      waits = 0;
      issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_cdp, 1'b0, 16'h0000, 16'h0001));
      issue(mk(llp_k_normal, llp_r_none, k ? llp_r_cdp : llp_r_ar1, llp_r_none, 1'b0,
        16'h0000, 16'h0002));
      drain(8);
      cmpn(k ? 4 : 0, waits);
    end
    $display("test granularity done");
    w = 16'(rnd()) & 16'h0003;
    i_x_wdata <= w;
    repeat (int'(w) + 1) exp_q.push_back(w);
    waits = 0;
    issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_csr, 1'b0, 16'h0000, 16'h0003));
    issue(mk(llp_k_single, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0004));
    issue(mk(llp_k_normal, llp_r_csr, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0005));
    drain(12);
    cmpn(4 + int'(w), waits);
    rd(`LLP_OFF_RPT, {w, 16'h0000}, 1'b0);
    $display("test source interlock done");
    w = 16'(rnd());
    repeat (4) exp_q.push_back(w);
    waits = 0;
    issue(mk(llp_k_imm, llp_r_none, llp_r_none, llp_r_csr, 1'b0, w, 16'h0006));
    issue(mk(llp_k_normal, llp_r_csr, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0007));
    issue(mk(llp_k_single, llp_r_none, llp_r_none, llp_r_none, 1'b1, 16'h0002, 16'h0008));
    issue(mk(llp_k_normal, llp_r_csr, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0009));
    drain(12);
    cmpn(2, waits);
    $display("test immediate repeat done");
    n = (16'(rnd()) & 16'h0003) + 16'h0001;
    issue(mk(llp_k_imm, llp_r_none, llp_r_none, llp_r_block_iteration_counter_1, 1'b0, n, 16'h000A));
    drain(8);
    rd(`LLP_OFF_BRS, {16'h0000, n}, 1'b0);
    rd(`LLP_OFF_BRC, {n, 16'h0000}, 1'b0);
    $display("test save mirror done");
    issue(mk(llp_k_imm, llp_r_none, llp_r_none, llp_r_block_iteration_counter_0, 1'b0, n, 16'h000B));
    issue(mk(llp_k_block, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0012, 16'h0010));
    for (int it = 0; it <= int'(n); it++) begin
      waits = 0;
      saw_redir = 1'b0;
      exp_q.push_back(n - 16'(it));
      issue(mk(llp_k_normal, llp_r_block_iteration_counter_0, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0011));
      issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0012));
      drain(8);
      cmpn(4, waits);
      cmp({31'h0, it < int'(n)}, {31'h0, saw_redir});
      if (saw_redir === 1'b1) cmp(32'h00000011, {16'h0, o_redirect_pc});
    end
    rd(`LLP_OFF_LOOP0, 32'h00120011, 1'b0);
    rd(`LLP_OFF_STATUS, 32'h00000000, 1'b0);
    $display("test block loop done");
    i_x_wdata <= 16'h0000;
    waits = 0;
    issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_block_iteration_counter_1, 1'b0, 16'h0000, 16'h001F));
    b = mk(llp_k_block, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0022, 16'h0020);
    b.level = 1'b1;
    issue(b);
    issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0021));
    issue(mk(llp_k_normal, llp_r_none, llp_r_none, llp_r_none, 1'b0, 16'h0000, 16'h0022));
    drain(8);
    cmpn(4, waits);
    rd(`LLP_OFF_LOOP1, 32'h00220021, 1'b0);
    rd(`LLP_OFF_STATUS, 32'h00000000, 1'b0);
    $display("test save interlock done");
    cmpn(0, exp_q.size());
    wrap_up();
  end
endmodule
